// ---- ipwc_top.sv ----
/*
  Interrupt priority and wake-up controller: external pin groups,
  fixed vector map, software priorities, WAIT/HALT sequencing.
  Assumes a CPU that takes vectors on cpu_take_i and reports its
  current CC priority bits, peripherals with level requests, and a
  classic Wishbone master on the same clock.
*/
// Operation
// - Port C control bits 5:4 set sensitivity shared by pins nine and ten.
// - Codes: 00 fall plus low, 01 rise, 10 fall, 11 both edges.
// - Port C control bits 3:0 enable each pin's external interrupt.
// - Vectors are fixed word pairs: reset top, trap, then sources down.
// - Reset beats trap, trap beats sources, lower source number wins.
// - Port A pins feed source 2, port B source 3, port C 4.
// - Only reset, NMI, end suspend, pin groups, timer, SPI end HALT.
// - Four priority banks at 32h-35h reset to ones; unused pairs read one.
// - WAIT stops the CPU, peripherals and the oscillator keep running.
// - In WAIT the CPU interrupt mask is forced open.
// - WAIT ends on any interrupt or reset, branching to its vector.
// - On service CC is pushed and the priority bits loaded.
// - HALT stops the oscillator and every peripheral.
// - Entering HALT clears the mask so wake interrupts can act.
// - HALT ends on NMI, end suspend, pin, timer or SPI interrupt, or reset; oscillator restarts.
// - CPU is held 514 clock cycles after the oscillator restarts.
// - After the delay the waking interrupt or reset vector is taken.
// - Pin edges are latched and cleared when their routine is entered.
// - Enabled pins of one line are combined by NAND, masking each other.
// - Requests serve only if enabled and priority beats current, else pend.
// - Writing the level-zero code to a pair keeps the old pair.
`timescale 1ns/10ps
`default_nettype none

module ipwc_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt sources
  input  wire logic [12:1] external_irq_pin_i,
  input  wire logic [10:0] periph_req_i,
  input  wire logic        trap_i,
  // CPU side
  input  wire logic        cpu_wfi_i,
  input  wire logic        cpu_halt_i,
  input  wire logic        cpu_take_i,
  input  wire logic [1:0]  cpu_prio_i,
  output logic             irq_req_o,
  output logic [15:0]      irq_vector_o,
  output logic [1:0]       irq_level_o,
  output logic             cc_push_o,
  output logic             cc_unmask_o,
  // Clock control
  output logic             cpu_run_o,
  output logic             osc_en_o,
  output logic             periph_clk_en_o
);

  typedef struct packed {
    ipwc_pkg::ipwc_mode_t mode;
    logic [9:0]           cnt;
    logic [7:0]           ctl_ab;
    logic [7:0]           ctl_c;
    logic [21:0]          prio;
    logic [2:0]           pend;
    logic                 trap;
    logic                 boot;
    logic                 halt_first;
    logic [12:1]          sync1;
    logic [12:1]          sync2;
    logic                 req;
    logic [3:0]           src;
    logic [15:0]          vec;
    logic [1:0]           lvl;
    logic                 push;
    logic                 ack;
    logic [7:0]           rdat;
  } ipwc_state_t;

  localparam ipwc_state_t RESET_STATE = '{
    mode:       ipwc_pkg::MODE_START,
    cnt:        '0,
    ctl_ab:     ipwc_pkg::CTL_RESET,
    ctl_c:      ipwc_pkg::CTL_RESET,
    prio:       {ipwc_pkg::NSRC{ipwc_pkg::PRIO_RESET}},
    pend:       '0,
    trap:       1'b0,
    boot:       1'b1,
    halt_first: 1'b0,
    sync1:      '0,
    sync2:      '0,
    req:        1'b0,
    src:        '0,
    vec:        '0,
    lvl:        '0,
    push:       1'b0,
    ack:        1'b0,
    rdat:       '0
  };

  ipwc_state_t s_r;
  ipwc_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Priority code to rank: level 0 lowest, level 3 highest
  function automatic logic [1:0] rank(input logic [1:0] p);
    case (p)
      2'h2:    rank = 2'h0;
      2'h1:    rank = 2'h1;
      2'h0:    rank = 2'h2;
      default: rank = 2'h3;
    endcase
  endfunction

  function automatic logic [7:0] bank_rd(input logic [21:0] prio,
                                         input logic [1:0]  bank);
    int x;
    bank_rd = '0;
    for (int k = 0; k < 4; k++) begin
      x = 4 * int'(bank) + k;
      if (x >= ipwc_pkg::FIRST_PAIR && x <= ipwc_pkg::LAST_PAIR) begin
        bank_rd[2*k +: 2] = prio[2*x +: 2];
      end else begin
        bank_rd[2*k +: 2] = ipwc_pkg::UNUSED_PAIR;
      end
    end
  endfunction

  function automatic logic [21:0] bank_wr(input logic [21:0] prio,
                                          input logic [1:0]  bank,
                                          input logic [7:0]  wdat);
    int x;
    bank_wr = prio;
    for (int k = 0; k < 4; k++) begin
      x = 4 * int'(bank) + k;
      if (x >= ipwc_pkg::FIRST_PAIR && x <= ipwc_pkg::LAST_PAIR &&
          wdat[2*k +: 2] != ipwc_pkg::PRIO_LEVEL0) begin
        bank_wr[2*x +: 2] = wdat[2*k +: 2];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin groups: A 1-4, B 5-6, B 7-8, C 9-10, C 11-12

  logic [3:0] g_pins [5];
  logic [3:0] g_en   [5];
  logic [1:0] g_sens [5];
  logic [4:0] g_evt;
  logic [4:0] g_low;

  assign g_pins[0] = s_r.sync2[4:1];
  assign g_en[0]   = s_r.ctl_ab[3:0];
  assign g_sens[0] = ipwc_pkg::SENS_FALL;
  assign g_pins[1] = {2'h3, s_r.sync2[6:5]};
  assign g_en[1]   = {2'h0, s_r.ctl_ab[5:4]};
  assign g_sens[1] = ipwc_pkg::SENS_RISE;
  assign g_pins[2] = {2'h3, s_r.sync2[8:7]};
  assign g_en[2]   = {2'h0, s_r.ctl_ab[7:6]};
  assign g_sens[2] = ipwc_pkg::SENS_FALL;
  assign g_pins[3] = {2'h3, s_r.sync2[10:9]};
  assign g_en[3]   = {2'h0, s_r.ctl_c[ipwc_pkg::C_EN_LSB +: 2]};
  assign g_sens[3] = s_r.ctl_c[ipwc_pkg::C_SENS_LO +: 2];
  assign g_pins[4] = {2'h3, s_r.sync2[12:11]};
  assign g_en[4]   = {2'h0, s_r.ctl_c[ipwc_pkg::C_EN_LSB+2 +: 2]};
  assign g_sens[4] = s_r.ctl_c[ipwc_pkg::C_SENS_HI +: 2];

  for (genvar g = 0; g < 5; g++) begin : gen_grp
    ipwc_pin_group u_grp (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pins_i  (g_pins[g]),
      .en_i    (g_en[g]),
      .sens_i  (g_sens[g]),
      .event_o (g_evt[g]),
      .low_o   (g_low[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [ipwc_pkg::NSRC-1:0] raw;
    logic [ipwc_pkg::NSRC-1:0] elig;
    logic [2:0]                grp_evt;
    logic [1:0]                cur;
    logic                      found;
    logic [3:0]                pick;
    logic                      take;
    logic [5:0]                idx;
    logic                      wr;
    logic [7:0]                rd;
    raw     = '0;
    elig    = '0;
    grp_evt = '0;
    cur     = '0;
    found   = 1'b0;
    pick    = '0;
    take    = 1'b0;
    idx     = wb_adr_i[7:2];
    wr      = 1'b0;
    rd      = '0;
    s_nxt   = s_r;

    // Pins come from outside: two flops before use
    s_nxt.sync1 = external_irq_pin_i;
    s_nxt.sync2 = s_r.sync1;

    take    = s_r.req & cpu_take_i;
    grp_evt = {g_evt[4] | g_evt[3], g_evt[2] | g_evt[1], g_evt[0]};

    // Edge latches: a new edge wins over the clear by take
    for (int j = 0; j < 3; j++) begin
      if (take && s_r.src == ipwc_pkg::SRC_PORT_A + 4'(j) &&
          s_r.vec != ipwc_pkg::VEC_RESET &&
          s_r.vec != ipwc_pkg::VEC_TRAP) begin
        s_nxt.pend[j] = 1'b0;
      end
      if (grp_evt[j]) begin
        s_nxt.pend[j] = 1'b1;
      end
    end

    // Request vector: peripherals by level, pin groups by latch, port C low level direct
    raw    = periph_req_i;
    raw[2] = s_r.pend[0];
    raw[3] = s_r.pend[1];
    raw[4] = s_r.pend[2] | g_low[3] | g_low[4];

    // Forced-open mask outside run
    cur = (s_r.mode == ipwc_pkg::MODE_RUN) ? rank(cpu_prio_i) : 2'h0;
    for (int i = 0; i < ipwc_pkg::NSRC; i++) begin
      elig[i] = raw[i] && (rank(s_r.prio[2*i +: 2]) > cur);
    end
    if (s_r.mode == ipwc_pkg::MODE_HALT || s_r.halt_first) begin
      elig = elig & ipwc_pkg::HALT_WAKE;
    end
    for (int i = ipwc_pkg::NSRC - 1; i >= 0; i--) begin
      if (elig[i]) begin
        found = 1'b1;
        pick  = 4'(i);
      end
    end

    // Reset and trap flags
    if (take && s_r.vec == ipwc_pkg::VEC_RESET) begin
      s_nxt.boot = 1'b0;
    end
    if (take && s_r.vec == ipwc_pkg::VEC_TRAP) begin
      s_nxt.trap = 1'b0;
    end
    if (trap_i) begin
      s_nxt.trap = 1'b1;
    end
    if (take && s_r.vec != ipwc_pkg::VEC_RESET &&
        s_r.vec != ipwc_pkg::VEC_TRAP) begin
      s_nxt.halt_first = 1'b0;
    end

    // Vector presentation, reset then trap then sources
    if (s_r.boot) begin
      s_nxt.vec = ipwc_pkg::VEC_RESET;
      s_nxt.lvl = ipwc_pkg::LEVEL_TOP;
    end else if (s_r.trap) begin
      s_nxt.vec = ipwc_pkg::VEC_TRAP;
      s_nxt.lvl = ipwc_pkg::LEVEL_TOP;
    end else begin
      s_nxt.vec = ipwc_pkg::VEC_SRC0 - {11'h000, pick, 1'b0};
      s_nxt.lvl = s_r.prio[2*pick +: 2];
    end
    s_nxt.src  = pick;
    s_nxt.req  = (s_r.mode == ipwc_pkg::MODE_RUN) &
                 (s_r.boot | s_r.trap | found) & ~take;
    s_nxt.push = take;

    // Power modes
    case (s_r.mode)
      ipwc_pkg::MODE_RUN: begin
        if (cpu_halt_i) begin
          s_nxt.mode = ipwc_pkg::MODE_HALT;
        end else if (cpu_wfi_i) begin
          s_nxt.mode = ipwc_pkg::MODE_WAIT;
        end
      end
      ipwc_pkg::MODE_WAIT: begin
        if (found) begin
          s_nxt.mode = ipwc_pkg::MODE_RUN;
        end
      end
      ipwc_pkg::MODE_HALT: begin
        if (found) begin
          s_nxt.mode       = ipwc_pkg::MODE_START;
          s_nxt.cnt        = '0;
          s_nxt.halt_first = 1'b1;
        end
      end
      ipwc_pkg::MODE_START: begin
        if (s_r.cnt == ipwc_pkg::STARTUP_CYC - 10'd1) begin
          s_nxt.mode = ipwc_pkg::MODE_RUN;
          s_nxt.cnt  = '0;
        end else begin
          s_nxt.cnt = s_r.cnt + 10'd1;
        end
      end
      default: begin
        s_nxt.mode = ipwc_pkg::MODE_RUN;
      end
    endcase

    // Register read mux
    case (idx)
      ipwc_pkg::IDX_AB_CTL: rd = s_r.ctl_ab;
      ipwc_pkg::IDX_PRIO0:  rd = bank_rd(s_r.prio, 2'd0);
      ipwc_pkg::IDX_PRIO1:  rd = bank_rd(s_r.prio, 2'd1);
      ipwc_pkg::IDX_PRIO2:  rd = bank_rd(s_r.prio, 2'd2);
      ipwc_pkg::IDX_PRIO3:  rd = bank_rd(s_r.prio, 2'd3);
      ipwc_pkg::IDX_C_CTL:  rd = s_r.ctl_c;
      ipwc_pkg::IDX_STATUS: rd = {s_r.halt_first, s_r.boot, s_r.trap,
                                  s_r.pend, s_r.mode};
      default:              rd = '0;
    endcase
    if (wb_adr_i[1:0] != 2'h0) begin
      rd = '0;
    end

    // Wishbone: ack one cycle after the request, write with the ack
    s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
    if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
      s_nxt.rdat = rd;
    end
    wr = s_r.ack & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] &
         (wb_adr_i[1:0] == 2'h0);
    if (wr) begin
      case (idx)
        ipwc_pkg::IDX_AB_CTL: s_nxt.ctl_ab = wb_dat_i[7:0];
        ipwc_pkg::IDX_PRIO0:
          s_nxt.prio = bank_wr(s_r.prio, 2'd0, wb_dat_i[7:0]);
        ipwc_pkg::IDX_PRIO1:
          s_nxt.prio = bank_wr(s_r.prio, 2'd1, wb_dat_i[7:0]);
        ipwc_pkg::IDX_PRIO2:
          s_nxt.prio = bank_wr(s_r.prio, 2'd2, wb_dat_i[7:0]);
        ipwc_pkg::IDX_PRIO3:
          s_nxt.prio = bank_wr(s_r.prio, 2'd3, wb_dat_i[7:0]);
        ipwc_pkg::IDX_C_CTL:  s_nxt.ctl_c = wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_dat_o        = {24'h000000, s_r.rdat};
  assign wb_ack_o        = s_r.ack;
  assign irq_req_o       = s_r.req;
  assign irq_vector_o    = s_r.vec;
  assign irq_level_o     = s_r.lvl;
  assign cc_push_o       = s_r.push;
  // Mask open whenever the CPU sleeps or waits for the oscillator
  assign cc_unmask_o     = (s_r.mode != ipwc_pkg::MODE_RUN);
  assign cpu_run_o       = (s_r.mode == ipwc_pkg::MODE_RUN);
  assign osc_en_o        = (s_r.mode != ipwc_pkg::MODE_HALT);
  assign periph_clk_en_o = (s_r.mode == ipwc_pkg::MODE_RUN) |
                           (s_r.mode == ipwc_pkg::MODE_WAIT);

endmodule

`default_nettype wire

// ---- ipwc_pkg.sv ----
/*
  Constants, register map and mode encoding of the interrupt priority
  and wake-up controller. Assumes a byte-wide register file reached as
  one 32-bit word per register index over classic Wishbone.
*/
package ipwc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Sources and register indices (byte address = index * 4)
  localparam int         NSRC        = 11;
  localparam int         IDX_W       = 6;
  localparam logic [5:0] IDX_AB_CTL  = 6'h08;
  localparam logic [5:0] IDX_PRIO0   = 6'h32;
  localparam logic [5:0] IDX_PRIO1   = 6'h33;
  localparam logic [5:0] IDX_PRIO2   = 6'h34;
  localparam logic [5:0] IDX_PRIO3   = 6'h35;
  localparam logic [5:0] IDX_C_CTL   = 6'h39;
  localparam logic [5:0] IDX_STATUS  = 6'h3A;

  ////////////////////////////////////////////////////////////////////////
  // Reset values and fields
  localparam logic [7:0] CTL_RESET    = 8'h00;
  localparam logic [1:0] PRIO_RESET   = 2'h3;
  localparam logic [1:0] PRIO_LEVEL0  = 2'h2;
  localparam logic [1:0] LEVEL_TOP    = 2'h3;
  localparam logic [1:0] UNUSED_PAIR  = 2'h3;
  localparam int         C_EN_LSB     = 0;
  localparam int         C_SENS_LO    = 4;
  localparam int         C_SENS_HI    = 6;
  localparam int         FIRST_PAIR   = 1;
  localparam int         LAST_PAIR    = 10;

  ////////////////////////////////////////////////////////////////////////
  // Pin sensitivity codes
  localparam logic [1:0] SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] SENS_RISE     = 2'h1;
  localparam logic [1:0] SENS_FALL     = 2'h2;
  localparam logic [1:0] SENS_BOTH     = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // Vectors, sources, wake set, timing
  localparam logic [15:0] VEC_RESET  = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP   = 16'hFFFC;
  localparam logic [15:0] VEC_SRC0   = 16'hFFFA;
  localparam logic [3:0]  SRC_PORT_A = 4'h2;
  localparam logic [3:0]  SRC_PORT_B = 4'h3;
  localparam logic [3:0]  SRC_PORT_C = 4'h4;
  localparam logic [10:0] HALT_WAKE  = 11'h0DF;
  localparam int          CNT_W      = 10;
  localparam logic [9:0]  STARTUP_CYC = 10'd514;

  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_WAIT  = 2'b01,
    MODE_HALT  = 2'b10,
    MODE_START = 2'b11
  } ipwc_mode_t;

endpackage

// ---- ipwc_pin_group.sv ----
/*
  One group of up to four external interrupt pins folded onto one line.
  Assumes pins are already synchronised to clk_i.
*/
`timescale 1ns/10ps
`default_nettype none

module ipwc_pin_group (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Pins and setup
  input  wire logic [3:0] pins_i,
  input  wire logic [3:0] en_i,
  input  wire logic [1:0] sens_i,
  // Request
  output logic            event_o,
  output logic            low_o
);

  typedef struct packed {
    logic line;
  } ipwc_grp_state_t;

  ipwc_grp_state_t s_r;
  ipwc_grp_state_t s_nxt;
  logic            line;

  // Any enabled low pin holds the line, masking the others
  assign line = ~&(pins_i | ~en_i);

  always_comb begin
    s_nxt      = s_r;
    s_nxt.line = line;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    case (sens_i)
      ipwc_pkg::SENS_FALL_LOW: event_o = line & ~s_r.line;
      ipwc_pkg::SENS_RISE:     event_o = ~line & s_r.line;
      ipwc_pkg::SENS_FALL:     event_o = line & ~s_r.line;
      default:                 event_o = line ^ s_r.line;
    endcase
  end

  assign low_o = (sens_i == ipwc_pkg::SENS_FALL_LOW) & line;

endmodule

`default_nettype wire

// ---- ipwc_chk.sv ----
/* Port checker for ipwc_top, bound at the foot of this file.
   Assumes one clock domain and a reset held for at least one edge. */
`timescale 1ns/10ps
`default_nettype none
module ipwc_chk (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // Cpu side and clocks
  input wire logic        cpu_wfi_i,
  input wire logic        cpu_halt_i,
  input wire logic        cpu_take_i,
  input wire logic [1:0]  cpu_prio_i,
  input wire logic        irq_req_o,
  input wire logic [15:0] irq_vector_o,
  input wire logic [1:0]  irq_level_o,
  input wire logic        cc_push_o,
  input wire logic        cc_unmask_o,
  input wire logic        cpu_run_o,
  input wire logic        osc_en_o,
  input wire logic        periph_clk_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  // Startup cycles judged only after a halt; reset startup is counted but not judged
  logic [9:0] cnt_r;
  logic       halt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= 10'h000;
      halt_r <= 1'b0;
    end else begin
      cnt_r  <= (osc_en_o && !periph_clk_en_o) ? cnt_r + 10'h001 : 10'h000;
      halt_r <= !osc_en_o || (halt_r && !cpu_run_o);
    end
  end
  function automatic logic [1:0] rank(input logic [1:0] c);
    rank = (c == 2'h3) ? 2'h3 : 2'h2 - c;
  endfunction
  sequence take_s;
    irq_req_o && cpu_take_i;
  endsequence
  sequence after_take_s;
    cc_push_o && !irq_req_o ##1 !cc_push_o;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle after request");
  take_push_a: assert property (take_s |=> after_take_s)
    else $error("take did not push and drop the request");
  fixed_level_a: assert property (irq_req_o && irq_vector_o >= 16'hFFFC |->
    irq_level_o == 2'h3) else $error("reset or trap level wrong");
  vec_range_a: assert property (irq_req_o |-> !irq_vector_o[0] &&
    irq_vector_o >= 16'hFFE6) else $error("vector outside map");
  halt_stop_a: assert property (!osc_en_o |-> !cpu_run_o &&
    !periph_clk_en_o) else $error("clocks live in halt");
  mask_open_a: assert property (!cpu_run_o |-> cc_unmask_o)
    else $error("mask not forced open");
  wait_entry_a: assert property (cpu_run_o && cpu_wfi_i && !cpu_halt_i |=>
    !cpu_run_o && periph_clk_en_o) else $error("wait entry wrong");
  halt_entry_a: assert property (cpu_run_o && cpu_halt_i |=> !osc_en_o)
    else $error("halt entry wrong");
  startup_len_a: assert property ($rose(cpu_run_o) && halt_r |->
    cnt_r == 10'd514) else $error("startup length wrong");
  prio_beat_a: assert property (irq_req_o && cpu_run_o && $past(cpu_run_o)
    && irq_vector_o < 16'hFFFC |-> rank(irq_level_o) >
    rank($past(cpu_prio_i))) else $error("request not above level");
endmodule
bind ipwc_top ipwc_chk i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .cpu_wfi_i, .cpu_halt_i, .cpu_take_i, .cpu_prio_i, .irq_req_o,
  .irq_vector_o, .irq_level_o, .cc_push_o, .cc_unmask_o, .cpu_run_o,
  .osc_en_o, .periph_clk_en_o);
`default_nettype wire

// ---- ipwc_cpu_model.sv ----
/* Behavioural cpu core taking vectors from the controller.
   Assumes a held request level and runs only while cpu_run is high. */
`timescale 1ns/10ps
`default_nettype none
module ipwc_cpu_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Controller side
  input  wire logic       irq_req_i,
  input  wire logic [1:0] irq_level_i,
  input  wire logic       run_i,
  output logic            take_o,
  output logic [1:0]      prio_o,
  // Bench control
  input  wire logic       mask_i,
  input  wire logic       slow_i
);
  logic [2:0] wait_r;
  logic [2:0] hold_r;
  logic [1:0] lvl_r;
  // Mask stands for software raising its level to 3
  assign prio_o = mask_i ? 2'h3 : lvl_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_r <= 3'h0;
      hold_r <= 3'h0;
      lvl_r  <= 2'h3;
      take_o <= 1'b0;
    end else begin
      take_o <= run_i && irq_req_i && !take_o &&
                wait_r == (slow_i ? 3'h5 : 3'h1);
      wait_r <= (irq_req_i && !take_o) ? wait_r + 3'h1 : 3'h0;
      if (irq_req_i && take_o) begin
        lvl_r  <= irq_level_i;
        hold_r <= 3'h6;
      end else if (hold_r != 3'h0) begin
        hold_r <= hold_r - 3'h1;
        // Short routine, then back to main level
        if (hold_r == 3'h1) lvl_r <= 2'h2;
      end
    end
  end
endmodule
`default_nettype wire

// ---- irq_priority_wakeup_ctrl_test.sv ----
/* Self-checking bench for ipwc_top with the cpu model.
   Assumes ipwc_pkg, the design and the checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module irq_priority_wakeup_ctrl_test;
  logic        clk_i, rst_i, wb_cyc_i, wb_we_i, wb_ack_o, trap_i;
  logic        cpu_wfi_i, cpu_halt_i, cpu_take_i, irq_req_o, cc_push_o;
  logic        cc_unmask_o, cpu_run_o, osc_en_o, periph_clk_en_o;
  logic        mask, slow;
  logic [1:0]  cpu_prio_i, irq_level_o;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [12:1] external_irq_pin_i;
  logic [10:0] periph_req_i;
  logic [15:0] irq_vector_o;
  int          errors, cmp_count;
  wire logic       wb_stb_i = wb_cyc_i;
  wire logic [3:0] wb_sel_i = 4'h1;
  ipwc_top i_dut (.*);
  ipwc_cpu_model i_cpu (.clk_i, .rst_i, .irq_req_i(irq_req_o),
    .irq_level_i(irq_level_o), .run_i(cpu_run_o), .take_o(cpu_take_i),
    .prio_o(cpu_prio_i), .mask_i(mask), .slow_i(slow));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic limit(input int n);
    if (n >= 2000) begin
      errors++;
      $display("[FAIL] %0t wait ran out", $time);
      report_and_stop;
    end
  endtask
  task automatic bus(input logic we, input logic [5:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 2000) begin
      n++;
      @(posedge clk_i);
    end
    limit(n);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, {24'h0, e});
  endtask
  // Waits for a vector, judges it, then waits for the CC push
  task automatic serve(input logic [15:0] v, input logic [1:0] l);
    int n;
    n = 0;
    while (irq_req_o !== 1'b1 && n < 2000) begin
      n++;
      @(posedge clk_i);
    end
    limit(n);
    chk({16'h0, irq_vector_o}, {16'h0, v});
    chk({30'h0, irq_level_o}, {30'h0, l});
    while (cc_push_o !== 1'b1 && n < 2000) begin
      n++;
      @(posedge clk_i);
    end
    limit(n);
  endtask
  task automatic quiet(input int c);
    int h;
    h = 0;
    repeat (c) begin
      @(posedge clk_i);
      if (irq_req_o !== 1'b0) h++;
    end
    chk(h, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic s_regs;
    for (int i = 0; i < 4; i++)
      rd(ipwc_pkg::IDX_PRIO0 + 6'(i), 8'hFF);
    wr(ipwc_pkg::IDX_PRIO1, 8'hCF);
    wr(ipwc_pkg::IDX_PRIO1, 8'h64);
    rd(ipwc_pkg::IDX_PRIO1, 8'h44);
    wr(ipwc_pkg::IDX_PRIO0, 8'h00);
    rd(ipwc_pkg::IDX_PRIO0, 8'h03);
    wr(ipwc_pkg::IDX_PRIO3, 8'h00);
    rd(ipwc_pkg::IDX_PRIO3, 8'hFF);
    wr(ipwc_pkg::IDX_C_CTL, 8'h3F);
    rd(ipwc_pkg::IDX_C_CTL, 8'h3F);
    wr(6'h10, 8'h5A);
    rd(6'h10, 8'h00);
    wr(ipwc_pkg::IDX_AB_CTL, 8'hFF);
  endtask
  // Every sensitivity code on pin nine, falling then rising
  task automatic s_pins;
    for (int c = 0; c < 4; c++) begin
      wr(ipwc_pkg::IDX_C_CTL, {2'h0, 2'(c), 4'h1});
      external_irq_pin_i[9] <= 1'b0;
      if (c != 1) serve(16'hFFF2, 2'h0);
      if (c == 0) serve(16'hFFF2, 2'h0);
      else quiet(20);
      external_irq_pin_i[9] <= 1'b1;
      if (c[0]) serve(16'hFFF2, 2'h0);
      else quiet(20);
    end
    wr(ipwc_pkg::IDX_C_CTL, {2'h0, ipwc_pkg::SENS_FALL, 4'h3});
    external_irq_pin_i[9] <= 1'b0;
    serve(16'hFFF2, 2'h0);
    external_irq_pin_i[10] <= 1'b0;
    quiet(20);
    external_irq_pin_i <= 12'hFFF;
    repeat (20) @(posedge clk_i);
  endtask
  task automatic s_vec;
    logic [1:0] l [11] = '{2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0,
                           2'h1, 2'h3, 2'h3, 2'h3};
    for (int s = 0; s < 11; s++)
      if (s < 2 || s > 4) begin
        periph_req_i[s] <= 1'b1;
        serve(16'hFFFA - 16'(2 * s), l[s]);
        periph_req_i[s] <= 1'b0;
        repeat (4) @(posedge clk_i);
      end
    slow <= 1'b1;
    mask <= 1'b1;
    periph_req_i <= 11'h420;
    quiet(20);
    mask <= 1'b0;
    serve(16'hFFF0, 2'h1);
    periph_req_i[5] <= 1'b0;
    serve(16'hFFE6, 2'h3);
    periph_req_i <= 11'h001;
    trap_i <= 1'b1;
    @(posedge clk_i);
    trap_i <= 1'b0;
    serve(16'hFFFC, 2'h3);
    serve(16'hFFFA, 2'h3);
    periph_req_i <= 11'h000;
    slow <= 1'b0;
  endtask
  task automatic s_wait;
    cpu_wfi_i <= 1'b1;
    @(posedge clk_i);
    cpu_wfi_i <= 1'b0;
    quiet(20);
    chk(cpu_run_o, 1'b0);
    chk(periph_clk_en_o, 1'b1);
    chk(cc_unmask_o, 1'b1);
    periph_req_i[8] <= 1'b1;
    serve(16'hFFEA, 2'h3);
    periph_req_i[8] <= 1'b0;
  endtask
  // Non-waking source pends; the waking one is served first
  task automatic s_halt;
    cpu_halt_i <= 1'b1;
    @(posedge clk_i);
    cpu_halt_i <= 1'b0;
    periph_req_i[5] <= 1'b1;
    quiet(30);
    chk(osc_en_o, 1'b0);
    chk(periph_clk_en_o, 1'b0);
    periph_req_i[6] <= 1'b1;
    serve(16'hFFEE, 2'h0);
    periph_req_i[6] <= 1'b0;
    serve(16'hFFF0, 2'h1);
    periph_req_i[5] <= 1'b0;
    cpu_halt_i <= 1'b1;
    @(posedge clk_i);
    cpu_halt_i <= 1'b0;
    external_irq_pin_i[1] <= 1'b0;
    serve(16'hFFF6, 2'h0);
    external_irq_pin_i[1] <= 1'b1;
  endtask
  initial begin
    errors = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    external_irq_pin_i = 12'hFFF;
    periph_req_i = 11'h000;
    trap_i = 1'b0;
    cpu_wfi_i = 1'b0;
    cpu_halt_i = 1'b0;
    mask = 1'b0;
    slow = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    serve(16'hFFFE, 2'h3);
    s_regs;
    s_pins;
    s_vec;
    s_wait;
    s_halt;
    report_and_stop;
  end
endmodule
`default_nettype wire
